//--- inc/mcfg_pkg.sv
// mcfg_pkg: offsets, field positions and reset values of the MAC
// receive, transmit and flow-control configuration block.
// assumes a 32-bit register port addressed in bytes.
`default_nettype none
package mcfg_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_PAUSE_SEND_TRIGGER = 12'h004;
	localparam logic [11:0] OFS_PAUSE_ADDRESS_LOW = 12'h400;
	localparam logic [11:0] OFS_RECEIVER_CONFIG = 12'h404;
	localparam logic [11:0] OFS_TRANSMITTER_CONFIG = 12'h408;
	localparam logic [11:0] OFS_FLOW_CONTROL_CONFIG = 12'h40C;
	localparam logic [11:0] OFS_GAP_EXTENSION = 12'h41C;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_PATH_RESET = 31;
	localparam int BIT_OVERSIZE = 30;
	localparam int BIT_INBAND_FCS = 29;
	localparam int BIT_PATH_ENABLE = 28;
	localparam int BIT_VLAN = 27;
	localparam int BIT_HALF_DUPLEX = 26;
	localparam int BIT_LT_OFF = 25;
	localparam int BIT_GAP_ADJUST = 25;
	localparam int BIT_CL_OFF = 24;
	localparam int BIT_PAUSE_SEND = 30;
	localparam int BIT_PAUSE_HONOUR = 29;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_PAUSE_ADDRESS_LOW = 32'hDDCCBBAA;
	localparam logic [31:0] RST_RECEIVER_CONFIG = 32'h6800FFEE;
	localparam logic [31:0] RST_TRANSMITTER_CONFIG = 32'h4A000000;
	localparam logic [31:0] RST_FLOW_CONTROL_CONFIG = 32'h60000000;
	localparam logic [7:0] RST_GAP_EXTENSION = 8'h00;
	// writable bits of the receiver, transmitter and flow-control registers
	localparam logic [31:0] MSK_RECEIVER_CONFIG = 32'h7F00FFFF;
	localparam logic [31:0] MSK_TRANSMITTER_CONFIG = 32'h7E000000;
	localparam logic [31:0] MSK_FLOW_CONTROL_CONFIG = 32'h60000000;
	// ----------------------------------------------------------------
	// frame constants
	// ----------------------------------------------------------------
	localparam logic [15:0] VLAN_TPID = 16'h8100;
	localparam logic [13:0] STD_MAX_FRAME = 14'h05EE;
	localparam logic [13:0] VLAN_EXTRA = 14'h0004;
	localparam logic [8:0] MIN_GAP_CYCLES = 9'h00C;
	localparam int PAUSE_FIFO_DEPTH = 16;
	localparam int PAUSE_QUANTA_W = 16;
endpackage : mcfg_pkg
`default_nettype wire

//--- rtl/mcfg_top.sv
// mcfg_top: configuration registers for the MAC receive, transmit and
// flow-control paths, plus the pause-request buffer.
// assumes frame-activity inputs come from MAC logic on clock_i.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// pause request buffer
// ------------------------------------------------------------------
module mcfg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic full_q;
	logic push;
	logic load;

	assign push = in_valid_i && !full_q;
	assign load = (!out_valid_o || out_ready_i) && (count_q != '0);

	always_comb
	begin
		count_d = count_q;
		if (push && !load)
			count_d = count_q + CW'(1);
		else if (load && !push)
			count_d = count_q - CW'(1);
	end

	always_ff @(posedge clock_i)
	begin
		if (push)
			mem[wr_q] <= in_data_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
			in_ready_o <= 1'b1;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			if (load)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			count_q <= count_d;
			full_q <= (count_d == CW'(DEPTH));
			in_ready_o <= (count_d != CW'(DEPTH));
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end
		else if (load)
		begin
			out_valid_o <= 1'b1;
			out_data_o <= mem[rd_q];
		end
		else if (out_ready_i)
			out_valid_o <= 1'b0;
	end

	chk_full_flag_count:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		full_q == (count_q == CW'(DEPTH)))
	else $error("full flag disagrees with count");
endmodule : mcfg_fifo

// Contract
// - config writes accepted anytime; applied to a path only between frames
// - path reset bits act at once, not waiting for a gap
// - rx reset bit resets receiver and rx config, then reads zero
// - tx reset bit resets transmitter and tx config, then reads zero
// - 48-bit pause address from low word and rx config low half
// - first wire octet sits in the least significant address byte
// - rx oversize enable lets frames above standard maximum pass
// - rx in-band fcs passes fcs on, else strips; always checked
// - receiver ignores media activity while rx enable is clear
// - vlan enable handles tagged frames; rx limit grows four bytes
// - only type 0x8100 marks a frame as vlan tagged
// - length/type check off skips length/type validation
// - control length check off accepts long control frames
// - tx oversize enable allows sending above standard maximum
// - tx in-band fcs clear means transmitter appends fcs
// - transmit path runs only while tx enable is set
// - gap adjust extends 12-cycle minimum gap by extension value
// - trigger write with pause send enable queues a pause frame
// - pause honour inhibits tx on pause, else forwards the frame
// - reserved bits read zero whatever is written
module mcfg_top
	import mcfg_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic rx_in_frame_i,
	input wire logic tx_in_frame_i,
	input wire logic rx_hdr_valid_i,
	input wire logic [47:0] rx_dest_addr_i,
	input wire logic [15:0] rx_type_i,
	input wire logic rx_len_valid_i,
	input wire logic [13:0] rx_len_i,
	input wire logic rx_pause_seen_i,
	output logic rx_reset_o,
	output logic tx_reset_o,
	output logic rx_enable_o,
	output logic rx_strip_fcs_o,
	output logic length_type_check_off_o,
	output logic control_length_check_off_o,
	output logic [47:0] pause_station_address_o,
	output logic pause_addr_match_o,
	output logic rx_vlan_tagged_o,
	output logic rx_len_ok_o,
	output logic rx_pause_inhibit_o,
	output logic rx_pause_forward_o,
	output logic tx_enable_o,
	output logic tx_oversize_ok_o,
	output logic tx_append_fcs_o,
	output logic tx_vlan_enable_o,
	output logic [8:0] tx_gap_cycles_o,
	output logic pause_fifo_ready_o,
	output logic pause_req_valid_o,
	input wire logic pause_req_ready_i,
	output logic [15:0] pause_quanta_o
);
	// ----------------------------------------------------------------
	// programmed and applied register copies
	// ----------------------------------------------------------------
	logic [31:0] addr_lo_q;
	logic [31:0] rx_cfg_q;
	logic [31:0] tx_cfg_q;
	logic [31:0] fc_cfg_q;
	logic [7:0] gap_ext_q;
	logic [31:0] rx_act_q;
	logic [31:0] tx_act_q;
	logic [31:0] fc_act_q;
	logic [7:0] gap_act_q;
	logic [31:0] addr_act_q;
	logic wr_rx;
	logic wr_tx;
	logic rx_rst_req;
	logic tx_rst_req;
	logic trig_valid;
	logic fifo_ready;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	assign wr_rx = reg_write_i && hit(reg_addr_i, OFS_RECEIVER_CONFIG);
	assign wr_tx = reg_write_i && hit(reg_addr_i, OFS_TRANSMITTER_CONFIG);
	assign rx_rst_req = wr_rx && reg_wdata_i[BIT_PATH_RESET];
	assign tx_rst_req = wr_tx && reg_wdata_i[BIT_PATH_RESET];

	// ----------------------------------------------------------------
	// programmed registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i || rx_rst_req)
		begin
			addr_lo_q <= RST_PAUSE_ADDRESS_LOW;
			rx_cfg_q <= RST_RECEIVER_CONFIG;
		end
		else if (reg_write_i)
		begin
			if (hit(reg_addr_i, OFS_PAUSE_ADDRESS_LOW))
				addr_lo_q <= reg_wdata_i;
			if (wr_rx)
				rx_cfg_q <= reg_wdata_i & MSK_RECEIVER_CONFIG;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i || tx_rst_req)
		begin
			tx_cfg_q <= RST_TRANSMITTER_CONFIG;
			gap_ext_q <= RST_GAP_EXTENSION;
		end
		else if (reg_write_i)
		begin
			if (wr_tx)
				tx_cfg_q <= reg_wdata_i & MSK_TRANSMITTER_CONFIG;
			if (hit(reg_addr_i, OFS_GAP_EXTENSION))
				gap_ext_q <= reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
			fc_cfg_q <= RST_FLOW_CONTROL_CONFIG;
		else if (reg_write_i && hit(reg_addr_i, OFS_FLOW_CONTROL_CONFIG))
			fc_cfg_q <= reg_wdata_i & MSK_FLOW_CONTROL_CONFIG;
	end

	// ----------------------------------------------------------------
	// applied copies follow only between frames
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i || rx_rst_req)
		begin
			rx_act_q <= RST_RECEIVER_CONFIG;
			addr_act_q <= RST_PAUSE_ADDRESS_LOW;
		end
		else if (!rx_in_frame_i)
		begin
			rx_act_q <= rx_cfg_q;
			addr_act_q <= addr_lo_q;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i || tx_rst_req)
		begin
			tx_act_q <= RST_TRANSMITTER_CONFIG;
			gap_act_q <= RST_GAP_EXTENSION;
		end
		else if (!tx_in_frame_i)
		begin
			tx_act_q <= tx_cfg_q;
			gap_act_q <= gap_ext_q;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
			fc_act_q <= RST_FLOW_CONTROL_CONFIG;
		else if (!tx_in_frame_i)
			fc_act_q <= fc_cfg_q;
	end

	chk_config_hold_frame:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		rx_in_frame_i && $past(rx_in_frame_i) && !$past(rx_rst_req)
		|-> $stable(rx_act_q))
	else $error("rx config changed inside a frame");

	// ----------------------------------------------------------------
	// path resets and path controls
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			rx_reset_o <= 1'b0;
			tx_reset_o <= 1'b0;
		end
		else
		begin
			rx_reset_o <= rx_rst_req;
			tx_reset_o <= tx_rst_req;
		end
	end

	chk_rx_reset_now:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		rx_rst_req |=> rx_reset_o && rx_cfg_q == RST_RECEIVER_CONFIG
		&& rx_act_q == RST_RECEIVER_CONFIG)
	else $error("rx reset did not act at once");

	chk_tx_reset_now:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		tx_rst_req |=> tx_reset_o && tx_act_q == RST_TRANSMITTER_CONFIG)
	else $error("tx reset did not act at once");

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			rx_enable_o <= 1'b0;
			rx_strip_fcs_o <= 1'b0;
			length_type_check_off_o <= 1'b0;
			control_length_check_off_o <= 1'b0;
			tx_enable_o <= 1'b0;
			tx_oversize_ok_o <= 1'b0;
			tx_append_fcs_o <= 1'b0;
			tx_vlan_enable_o <= 1'b0;
			tx_gap_cycles_o <= MIN_GAP_CYCLES;
			pause_station_address_o <= '0;
		end
		else
		begin
			rx_enable_o <= rx_act_q[BIT_PATH_ENABLE];
			rx_strip_fcs_o <= !rx_act_q[BIT_INBAND_FCS];
			length_type_check_off_o <= rx_act_q[BIT_LT_OFF];
			control_length_check_off_o <= rx_act_q[BIT_CL_OFF];
			tx_enable_o <= tx_act_q[BIT_PATH_ENABLE];
			tx_oversize_ok_o <= tx_act_q[BIT_OVERSIZE];
			tx_append_fcs_o <= !tx_act_q[BIT_INBAND_FCS];
			tx_vlan_enable_o <= tx_act_q[BIT_VLAN];
			tx_gap_cycles_o <= tx_act_q[BIT_GAP_ADJUST]
				? MIN_GAP_CYCLES + {1'b0, gap_act_q} : MIN_GAP_CYCLES;
			pause_station_address_o <= {rx_act_q[15:0], addr_act_q};
		end
	end

	chk_gap_extension:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		##1 tx_gap_cycles_o == ($past(tx_act_q[BIT_GAP_ADJUST])
		? MIN_GAP_CYCLES + {1'b0, $past(gap_act_q)} : MIN_GAP_CYCLES))
	else $error("gap length wrong");

	// ----------------------------------------------------------------
	// receive header checks, gated by receive enable
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			pause_addr_match_o <= 1'b0;
			rx_vlan_tagged_o <= 1'b0;
		end
		else if (rx_hdr_valid_i && rx_act_q[BIT_PATH_ENABLE])
		begin
			pause_addr_match_o <= rx_dest_addr_i
				== {rx_act_q[15:0], addr_act_q};
			rx_vlan_tagged_o <= rx_act_q[BIT_VLAN]
				&& rx_type_i == VLAN_TPID;
		end
	end

	chk_vlan_tpid_only:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		rx_hdr_valid_i && rx_act_q[BIT_PATH_ENABLE]
		|=> rx_vlan_tagged_o == ($past(rx_type_i) == VLAN_TPID
		&& $past(rx_act_q[BIT_VLAN])))
	else $error("vlan tag decision wrong");

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
			rx_len_ok_o <= 1'b0;
		else if (rx_len_valid_i && rx_act_q[BIT_PATH_ENABLE])
			rx_len_ok_o <= rx_act_q[BIT_OVERSIZE]
				|| rx_len_i <= (rx_act_q[BIT_VLAN]
				? STD_MAX_FRAME + VLAN_EXTRA : STD_MAX_FRAME);
	end

	chk_oversize_reject:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		rx_len_valid_i && rx_act_q[BIT_PATH_ENABLE]
		&& !rx_act_q[BIT_OVERSIZE] && rx_len_i > STD_MAX_FRAME + VLAN_EXTRA
		|=> !rx_len_ok_o)
	else $error("oversize frame accepted");

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			rx_pause_inhibit_o <= 1'b0;
			rx_pause_forward_o <= 1'b0;
		end
		else
		begin
			rx_pause_inhibit_o <= rx_pause_seen_i
				&& rx_act_q[BIT_PATH_ENABLE] && fc_act_q[BIT_PAUSE_HONOUR];
			rx_pause_forward_o <= rx_pause_seen_i
				&& rx_act_q[BIT_PATH_ENABLE] && !fc_act_q[BIT_PAUSE_HONOUR];
		end
	end

	chk_pause_honour:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		rx_pause_seen_i && rx_act_q[BIT_PATH_ENABLE]
		|=> rx_pause_inhibit_o != rx_pause_forward_o)
	else $error("pause frame neither honoured nor forwarded");

	// ----------------------------------------------------------------
	// pause send trigger into the request buffer
	// ----------------------------------------------------------------
	assign trig_valid = reg_write_i && hit(reg_addr_i, OFS_PAUSE_SEND_TRIGGER)
		&& fc_act_q[BIT_PAUSE_SEND];

	mcfg_fifo #(
		.WIDTH(PAUSE_QUANTA_W),
		.DEPTH(PAUSE_FIFO_DEPTH)
	) u_pause_fifo (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.in_valid_i(trig_valid),
		.in_ready_o(fifo_ready),
		.in_data_i(reg_wdata_i[15:0]),
		.out_valid_o(pause_req_valid_o),
		.out_ready_i(pause_req_ready_i),
		.out_data_o(pause_quanta_o)
	);
	assign pause_fifo_ready_o = fifo_ready;

	chk_pause_send_gate:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		!pause_req_valid_o && u_pause_fifo.count_q == '0
		&& !u_pause_fifo.push ##1 !u_pause_fifo.push
		|=> !pause_req_valid_o)
	else $error("pause request without trigger");

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			reg_rdata_o <= '0;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_read_i;
			reg_rdata_o <= '0;
			if (reg_read_i)
			begin
				if (hit(reg_addr_i, OFS_PAUSE_ADDRESS_LOW))
					reg_rdata_o <= addr_lo_q;
				if (hit(reg_addr_i, OFS_RECEIVER_CONFIG))
					reg_rdata_o <= rx_cfg_q;
				if (hit(reg_addr_i, OFS_TRANSMITTER_CONFIG))
					reg_rdata_o <= tx_cfg_q;
				if (hit(reg_addr_i, OFS_FLOW_CONTROL_CONFIG))
					reg_rdata_o <= fc_cfg_q;
				if (hit(reg_addr_i, OFS_GAP_EXTENSION))
					reg_rdata_o <= {24'h000000, gap_ext_q};
			end
		end
	end

	chk_reserved_zero:
	assert property (@(posedge clock_i) disable iff (!rstn_i)
		reg_read_i && hit(reg_addr_i, OFS_TRANSMITTER_CONFIG)
		|=> reg_rvalid_o && reg_rdata_o[24:0] == 25'h0000000
		&& !reg_rdata_o[BIT_PATH_RESET])
	else $error("reserved or reset bit read nonzero");
endmodule : mcfg_top
`default_nettype wire

//--- bench/mcfg_pause_sink.sv
// mcfg_pause_sink: far-side stand-in that takes pause requests.
// assumes it shares clock_i with the block; slow_i holds it off.
`timescale 1ns/100ps
`default_nettype none
module mcfg_pause_sink (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic valid_i,
	input wire logic [15:0] quanta_i,
	input wire logic slow_i,
	output logic ready_o
);
	logic ready_q;
	logic [15:0] got_q[$];

	assign ready_o = ready_q;
	// ----------------------------------------------------------------
	// take one request a cycle unless stalled
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		ready_q <= rstn_i && !slow_i;
		if (rstn_i && valid_i && ready_q)
		begin
			got_q.push_back(quanta_i);
		end
	end
endmodule : mcfg_pause_sink
`default_nettype wire

//--- bench/tb_mcfg_top.sv
// tb_mcfg_top: self-checking bench for the MAC configuration block.
// assumes mcfg_pkg and the pause sink model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_mcfg_top;
	import mcfg_pkg::*;
	logic clock_i, rstn_i, reg_write_i, reg_read_i, reg_rvalid_o;
	logic [11:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic rx_in_frame_i, tx_in_frame_i, rx_hdr_valid_i, rx_len_valid_i;
	logic [47:0] rx_dest_addr_i, pause_station_address_o;
	logic [15:0] rx_type_i, pause_quanta_o;
	logic [13:0] rx_len_i;
	logic rx_pause_seen_i, rx_reset_o, tx_reset_o, rx_enable_o;
	logic rx_strip_fcs_o, length_type_check_off_o, control_length_check_off_o;
	logic pause_addr_match_o, rx_vlan_tagged_o, rx_len_ok_o;
	logic rx_pause_inhibit_o, rx_pause_forward_o, tx_enable_o;
	logic tx_oversize_ok_o, tx_append_fcs_o, tx_vlan_enable_o;
	logic pause_fifo_ready_o, pause_req_valid_o, pause_req_ready_i, slow;
	logic [8:0] tx_gap_cycles_o;
	logic [1:0] rst_seen;
	int err_count, cmp_count;

	mcfg_top mcfg_top_inst (.clock_i, .rstn_i, .reg_write_i, .reg_read_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
		.rx_in_frame_i, .tx_in_frame_i, .rx_hdr_valid_i, .rx_dest_addr_i,
		.rx_type_i, .rx_len_valid_i, .rx_len_i, .rx_pause_seen_i,
		.rx_reset_o, .tx_reset_o, .rx_enable_o, .rx_strip_fcs_o,
		.length_type_check_off_o, .control_length_check_off_o,
		.pause_station_address_o, .pause_addr_match_o, .rx_vlan_tagged_o,
		.rx_len_ok_o, .rx_pause_inhibit_o, .rx_pause_forward_o, .tx_enable_o,
		.tx_oversize_ok_o, .tx_append_fcs_o, .tx_vlan_enable_o,
		.tx_gap_cycles_o, .pause_fifo_ready_o, .pause_req_valid_o,
		.pause_req_ready_i, .pause_quanta_o);
	mcfg_pause_sink mcfg_pause_sink_inst (.clock_i, .rstn_i,
		.valid_i(pause_req_valid_o), .quanta_i(pause_quanta_o),
		.slow_i(slow), .ready_o(pause_req_ready_i));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [47:0] e,
		input logic [47:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		#1;
		reg_write_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(posedge clock_i);
		#1;
		rst_seen = {rx_reset_o, tx_reset_o};
		reg_write_i = 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock_i);
		#1;
		reg_read_i = 1'b1;
		reg_addr_i = a;
		@(posedge clock_i);
		#1;
		reg_read_i = 1'b0;
		chk("rvalid", 1, reg_rvalid_o);
		chk($sformatf("reg %h", a), e, reg_rdata_o);
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge clock_i);
		#1;
	endtask : settle

	// expected flags: match, tagged, length ok
	task automatic rxin(input logic [47:0] d, input logic [15:0] t,
		input logic [13:0] l, input logic [2:0] e);
		@(posedge clock_i);
		#1;
		{rx_hdr_valid_i, rx_len_valid_i} = 2'h3;
		rx_dest_addr_i = d;
		rx_type_i = t;
		rx_len_i = l;
		@(posedge clock_i);
		#1;
		{rx_hdr_valid_i, rx_len_valid_i} = 2'h0;
		chk("match", e[2], pause_addr_match_o);
		chk("tagged", e[1], rx_vlan_tagged_o);
		chk("len_ok", e[0], rx_len_ok_o);
	endtask : rxin

	task automatic pseen(input logic [1:0] e);
		@(posedge clock_i);
		#1;
		rx_pause_seen_i = 1'b1;
		@(posedge clock_i);
		#1;
		rx_pause_seen_i = 1'b0;
		chk("inhibit_forward", e, {rx_pause_inhibit_o, rx_pause_forward_o});
	endtask : pseen

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		rd(OFS_PAUSE_ADDRESS_LOW, RST_PAUSE_ADDRESS_LOW);
		rd(OFS_RECEIVER_CONFIG, RST_RECEIVER_CONFIG);
		rd(OFS_TRANSMITTER_CONFIG, RST_TRANSMITTER_CONFIG);
		rd(OFS_FLOW_CONTROL_CONFIG, RST_FLOW_CONTROL_CONFIG);
		rd(12'h010, 32'h00000000);
		chk("station", 48'hFFEEDDCCBBAA, pause_station_address_o);
		chk("gap", 12, tx_gap_cycles_o);
		chk("strip", 0, rx_strip_fcs_o);
		chk("append", 1, tx_append_fcs_o);
		chk("tx_over", 1, tx_oversize_ok_o);
		chk("en", 0, {rx_enable_o, tx_enable_o});
	endtask : t_defaults

	task automatic t_write_apply;
		rx_in_frame_i = 1'b1;
		wr(OFS_PAUSE_ADDRESS_LOW, 32'h44332211);
		wr(OFS_RECEIVER_CONFIG, 32'h1BFF6655);
		rd(OFS_RECEIVER_CONFIG, 32'h1B006655);
		settle;
		chk("rx_en_frame", 0, rx_enable_o);
		rx_in_frame_i = 1'b0;
		settle;
		chk("rx_en", 1, rx_enable_o);
		chk("strip", 1, rx_strip_fcs_o);
		chk("lt_off", 1, length_type_check_off_o);
		chk("cl_off", 1, control_length_check_off_o);
		chk("station", 48'h665544332211, pause_station_address_o);
		wr(OFS_TRANSMITTER_CONFIG, 32'h3BFFFFFF);
		wr(OFS_GAP_EXTENSION, 32'h00000005);
		wr(OFS_FLOW_CONTROL_CONFIG, 32'hFFFFFFFF);
		rd(OFS_TRANSMITTER_CONFIG, 32'h3A000000);
		rd(OFS_FLOW_CONTROL_CONFIG, 32'h60000000);
		settle;
		chk("tx_en", 1, tx_enable_o);
		chk("append", 0, tx_append_fcs_o);
		chk("tx_over", 0, tx_oversize_ok_o);
		chk("tx_vlan", 1, tx_vlan_enable_o);
		chk("gap", 17, tx_gap_cycles_o);
	endtask : t_write_apply

	task automatic t_rx;
		rxin(48'h665544332211, VLAN_TPID, 14'd1522, 3'b111);
		rxin(48'h665544332212, 16'h88A8, 14'd1523, 3'b000);
		wr(OFS_RECEIVER_CONFIG, 32'h50006655);
		settle;
		rxin(48'h665544332211, VLAN_TPID, 14'd3000, 3'b101);
		wr(OFS_RECEIVER_CONFIG, 32'h00006655);
		settle;
		rxin(48'h000000000001, VLAN_TPID, 14'd1519, 3'b101);
		wr(OFS_RECEIVER_CONFIG, 32'h10006655);
		settle;
		rxin(48'h665544332211, 16'h0800, 14'd1519, 3'b100);
	endtask : t_rx

	task automatic t_pause_rx;
		pseen(2'b10);
		wr(OFS_FLOW_CONTROL_CONFIG, 32'h40000000);
		settle;
		pseen(2'b01);
	endtask : t_pause_rx

	task automatic t_pause_fifo;
		slow = 1'b1;
		wr(OFS_FLOW_CONTROL_CONFIG, 32'h60000000);
		settle;
		for (int i = 0; i < 17; i++)
			wr(OFS_PAUSE_SEND_TRIGGER, 32'h0000A000 + i);
		settle;
		chk("fifo_ready", 0, pause_fifo_ready_o);
		chk("req_valid", 1, pause_req_valid_o);
		wr(OFS_PAUSE_SEND_TRIGGER, 32'h0000BEEF);
		slow = 1'b0;
		repeat (40) @(posedge clock_i);
		#1;
		chk("sent", 17, mcfg_pause_sink_inst.got_q.size());
		for (int i = 0; i < 17; i++)
			chk("quanta", 16'hA000 + i, mcfg_pause_sink_inst.got_q[i]);
		wr(OFS_FLOW_CONTROL_CONFIG, 32'h20000000);
		settle;
		wr(OFS_PAUSE_SEND_TRIGGER, 32'h00000001);
		settle;
		chk("sent_off", 17, mcfg_pause_sink_inst.got_q.size());
	endtask : t_pause_fifo

	task automatic t_path_reset;
		{rx_in_frame_i, tx_in_frame_i} = 2'h3;
		wr(OFS_RECEIVER_CONFIG, 32'h90006655);
		chk("rx_rst", 2'b10, rst_seen);
		rd(OFS_RECEIVER_CONFIG, RST_RECEIVER_CONFIG);
		rd(OFS_PAUSE_ADDRESS_LOW, RST_PAUSE_ADDRESS_LOW);
		chk("rx_en", 0, rx_enable_o);
		wr(OFS_TRANSMITTER_CONFIG, 32'h80000000);
		chk("tx_rst", 2'b01, rst_seen);
		rd(OFS_TRANSMITTER_CONFIG, RST_TRANSMITTER_CONFIG);
		rd(OFS_GAP_EXTENSION, 32'h00000000);
		rd(OFS_FLOW_CONTROL_CONFIG, 32'h20000000);
		chk("tx_en", 0, tx_enable_o);
		chk("append", 1, tx_append_fcs_o);
		chk("gap", 12, tx_gap_cycles_o);
		{rx_in_frame_i, tx_in_frame_i} = 2'h0;
	endtask : t_path_reset

	// ----------------------------------------------------------------
	// clock, main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	initial
	begin
		{rstn_i, reg_write_i, reg_read_i, rx_in_frame_i} = 4'h0;
		{tx_in_frame_i, rx_hdr_valid_i, rx_len_valid_i} = 3'h0;
		{rx_pause_seen_i, slow, rst_seen} = 4'h0;
		reg_addr_i = 12'h000;
		reg_wdata_i = 32'h00000000;
		rx_dest_addr_i = 48'h000000000000;
		rx_type_i = 16'h0000;
		rx_len_i = 14'h0000;
		err_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge clock_i);
		#1;
		rstn_i = 1'b1;
		settle;
		t_defaults;
		t_write_apply;
		t_rx;
		t_pause_rx;
		t_pause_fifo;
		t_path_reset;
		end_sim;
	end

	initial
	begin
		#100000;
		err_count++;
		end_sim;
	end
endmodule : tb_mcfg_top
`default_nettype wire
